// [design/dmb_mode_config.sv]
// Mode register bank: calibration self-test status, termination indicator,
// double-copy burst/preamble/recovery/postamble configuration, read order.
// Assumes commands come from a decoder on ref_clk; pad levels are async.
`timescale 1ns/1ps
`default_nettype none

module dmb_mode_config (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic [5:0] cmd_ma,
   input wire logic [7:0] cmd_op,
   input wire logic cmd_bl32,
   input wire logic cmd_ap,
   input wire logic [2:0] cmd_col,
   input wire logic wr_burst_end,
   input wire logic zq_tied_vssq,
   input wire logic [1:0] zq_detect,
   input wire logic ca_term_pad,
   output logic mrr_valid_q,
   output logic [7:0] mrr_data_q,
   output logic wr_preamble_2tck_q,
   output logic rd_preamble_toggle_q,
   output logic rd_postamble_long_q,
   output logic [5:0] write_recovery_cycles_q,
   output logic precharge_start_q,
   output logic driver_factory_trim_q,
   output logic zq_code_update_q,
   output logic zq_result_valid_q,
   output logic rd_word_valid_q,
   output logic [4:0] rd_word_addr_q,
   output logic rd_word_last_q
);

   // -----------------------------------------------------------------
   // Decoding helpers
   // -----------------------------------------------------------------
   // Write recovery code to clock count
   function automatic logic [5:0] nwr_count(input logic [2:0] code);
      case (code)
         3'h0: nwr_count = dmb_pkg::NWR_C0;
         3'h1: nwr_count = dmb_pkg::NWR_C1;
         3'h2: nwr_count = dmb_pkg::NWR_C2;
         3'h3: nwr_count = dmb_pkg::NWR_C3;
         3'h4: nwr_count = dmb_pkg::NWR_C4;
         3'h5: nwr_count = dmb_pkg::NWR_C5;
         3'h6: nwr_count = dmb_pkg::NWR_C6;
         default: nwr_count = dmb_pkg::NWR_C7;
      endcase
   endfunction

   // True when a command of the given kind is presented this cycle
   function automatic logic is_cmd(input logic v, input logic [2:0] c, input dmb_pkg::dmb_cmd_e k);
      is_cmd = v && (c == k);
   endfunction

   // -----------------------------------------------------------------
   // Pad synchronisers
   // -----------------------------------------------------------------
   logic [3:0] pad_meta_q;
   logic [3:0] pad_sync_q;

   // Pads are asynchronous levels; only the second stage is read
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pad_meta_q <= 4'h0;
         pad_sync_q <= 4'h0;
      end else begin
         pad_meta_q <= {ca_term_pad, zq_tied_vssq, zq_detect};
         pad_sync_q <= pad_meta_q;
      end
   end

   logic term_pad_s;
   logic tied_s;
   logic [1:0] detect_s;
   assign term_pad_s = pad_sync_q[3];
   assign tied_s = pad_sync_q[2];
   assign detect_s = pad_sync_q[1:0];

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   logic do_mrw;
   logic do_mrr;
   logic do_zq_begin;
   logic do_zq_apply;
   logic do_read;
   logic do_write;
   assign do_mrw = is_cmd(cmd_valid, cmd_code, dmb_pkg::CMD_MODE_REG_WRITE);
   assign do_mrr = is_cmd(cmd_valid, cmd_code, dmb_pkg::CMD_MODE_REG_READ);
   assign do_zq_begin = is_cmd(cmd_valid, cmd_code, dmb_pkg::CMD_ZQ_CAL_BEGIN);
   assign do_zq_apply = is_cmd(cmd_valid, cmd_code, dmb_pkg::CMD_ZQ_CAL_APPLY);
   assign do_read = is_cmd(cmd_valid, cmd_code, dmb_pkg::CMD_READ);
   assign do_write = is_cmd(cmd_valid, cmd_code, dmb_pkg::CMD_WRITE);

   // -----------------------------------------------------------------
   // Set-point selects and the two configuration copies
   // -----------------------------------------------------------------
   logic sp_write_q;
   logic sp_operate_q;
   logic [7:0] cfg_copy_q [2];

   // Set-point register write
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sp_write_q <= 1'b0;
         sp_operate_q <= 1'b0;
      end else if (do_mrw && cmd_ma == dmb_pkg::MA_SETPOINT) begin
         sp_write_q <= cmd_op[dmb_pkg::SP_WRITE_BIT];
         sp_operate_q <= cmd_op[dmb_pkg::SP_OPERATE_BIT];
      end
   end

   // Only the write-selected copy changes; the other may be active
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_copy_q[0] <= dmb_pkg::CFG_RESET;
         cfg_copy_q[1] <= dmb_pkg::CFG_RESET;
      end else if (do_mrw && cmd_ma == dmb_pkg::MA_BURST_PREAMBLE) begin
         cfg_copy_q[sp_write_q] <= cmd_op;
      end
   end

   // Active copy feeds all operating decisions
   logic [7:0] cfg_act;
   assign cfg_act = cfg_copy_q[sp_operate_q];

   // Registered operating controls; the reserved write preamble code
   // is not trapped, the controller must avoid it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_preamble_2tck_q <= dmb_pkg::CFG_RESET[dmb_pkg::CFG_WR_PRE_BIT];
         rd_preamble_toggle_q <= 1'b0;
         rd_postamble_long_q <= 1'b0;
         write_recovery_cycles_q <= dmb_pkg::NWR_C0;
      end else begin
         wr_preamble_2tck_q <= cfg_act[dmb_pkg::CFG_WR_PRE_BIT];
         rd_preamble_toggle_q <= cfg_act[dmb_pkg::CFG_RD_PRE_BIT];
         rd_postamble_long_q <= cfg_act[dmb_pkg::CFG_READ_POSTAMBLE_LEN_BIT];
         write_recovery_cycles_q <= nwr_count(cfg_act[dmb_pkg::CFG_NWR_LSB +: 3]);
      end
   end

   // -----------------------------------------------------------------
   // Calibration self-test sequence
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {
      ZQ_IDLE = 2'b00,
      ZQ_BEGUN = 2'b01,
      ZQ_WAIT = 2'b10,
      ZQ_DONE = 2'b11
   } dmb_zq_e;

   localparam int ZQW = $clog2(dmb_pkg::ZQ_APPLY_CYC + 1);

   dmb_zq_e zq_state_q;
   logic [ZQW-1:0] zq_cnt_q;
   logic [1:0] zq_result_q;
   logic zq_error_q;
   logic [1:0] zq_code;

   // Tied pin forces default-calibration code; otherwise the detector speaks
   assign zq_code = tied_s ? dmb_pkg::ZQ_DEFAULT_CAL : detect_s;

   // Reset drops the result, so it must be rebuilt by a new sequence
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         zq_state_q <= ZQ_IDLE;
         zq_cnt_q <= '0;
         zq_result_q <= dmb_pkg::ZQ_NONE;
         zq_result_valid_q <= 1'b0;
         zq_error_q <= 1'b0;
         zq_code_update_q <= 1'b0;
      end else begin
         zq_code_update_q <= 1'b0;
         case (zq_state_q)
            ZQ_IDLE, ZQ_DONE: begin
               if (do_zq_begin && !zq_error_q) begin
                  zq_state_q <= ZQ_BEGUN;
               end
            end
            ZQ_BEGUN: begin
               if (do_zq_apply && !zq_error_q) begin
                  zq_state_q <= ZQ_WAIT;
                  zq_cnt_q <= ZQW'(dmb_pkg::ZQ_APPLY_CYC);
               end
            end
            default: begin
               if (zq_cnt_q > ZQW'(1)) begin
                  zq_cnt_q <= zq_cnt_q - ZQW'(1);
               end else begin
                  // Apply wait over: result becomes trustworthy
                  zq_state_q <= ZQ_DONE;
                  zq_cnt_q <= '0;
                  zq_result_q <= zq_code;
                  zq_result_valid_q <= 1'b1;
                  if (!tied_s && (zq_code == dmb_pkg::ZQ_DEFAULT_CAL || zq_code == dmb_pkg::ZQ_OPEN_OR_SHORT)) begin
                     zq_error_q <= 1'b1;
                  end else begin
                     zq_code_update_q <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Factory trim whenever the last result flagged a suspect pin
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         driver_factory_trim_q <= 1'b0;
      end else begin
         driver_factory_trim_q <= zq_error_q;
      end
   end

   // -----------------------------------------------------------------
   // Mode register read answers
   // -----------------------------------------------------------------
   logic [7:0] status_word;
   always_comb begin
      status_word = 8'h00;
      status_word[dmb_pkg::STS_TERM_BIT] = term_pad_s;
      status_word[dmb_pkg::STS_ZQ_LSB +: 2] = zq_result_valid_q ? zq_result_q : dmb_pkg::ZQ_NONE;
   end

   // One-cycle answer after the read; unmapped addresses read zero
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mrr_valid_q <= 1'b0;
         mrr_data_q <= 8'h00;
      end else begin
         mrr_valid_q <= do_mrr;
         if (do_mrr) begin
            if (cmd_ma == dmb_pkg::MA_STATUS) begin
               mrr_data_q <= status_word;
            end else if (cmd_ma == dmb_pkg::MA_BURST_PREAMBLE) begin
               mrr_data_q <= cfg_copy_q[sp_write_q];
            end else if (cmd_ma == dmb_pkg::MA_SETPOINT) begin
               mrr_data_q <= {sp_operate_q, sp_write_q, 6'h00};
            end else begin
               mrr_data_q <= 8'h00;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Write with auto-precharge: recovery countdown
   // -----------------------------------------------------------------
   logic ap_pending_q;
   logic [5:0] wr_cnt_q;
   logic wr_cnt_run_q;

   // Count starts when the burst ends; a new AP write while counting is
   // queued only once, a trade for a single counter
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ap_pending_q <= 1'b0;
         wr_cnt_q <= 6'h00;
         wr_cnt_run_q <= 1'b0;
         precharge_start_q <= 1'b0;
      end else begin
         precharge_start_q <= 1'b0;
         if (wr_burst_end && ap_pending_q && !wr_cnt_run_q) begin
            ap_pending_q <= do_write && cmd_ap;
            wr_cnt_q <= write_recovery_cycles_q;
            wr_cnt_run_q <= 1'b1;
         end else if (do_write && cmd_ap) begin
            ap_pending_q <= 1'b1;
         end
         if (wr_cnt_run_q) begin
            if (wr_cnt_q == 6'h01) begin
               wr_cnt_run_q <= 1'b0;
               precharge_start_q <= 1'b1;
            end
            wr_cnt_q <= wr_cnt_q - 6'h01;
         end
      end
   end

   // -----------------------------------------------------------------
   // Read burst length and word order
   // -----------------------------------------------------------------
   logic [1:0] bl_code;
   logic rd_len32;
   assign bl_code = cfg_act[dmb_pkg::CFG_BL_LSB +: 2];

   // Fixed 32, on-the-fly from the command, otherwise 16
   always_comb begin
      if (bl_code == dmb_pkg::BL_FIXED32) begin
         rd_len32 = 1'b1;
      end else if (bl_code == dmb_pkg::BL_ON_THE_FLY) begin
         rd_len32 = cmd_bl32;
      end else begin
         rd_len32 = 1'b0;
      end
   end

   dmb_read_burst_seq u_seq (
      .ref_clk(ref_clk),
      .rst(rst),
      .start(do_read),
      .len32(rd_len32),
      .col(cmd_col),
      .word_valid_q(rd_word_valid_q),
      .word_addr_q(rd_word_addr_q),
      .word_last_q(rd_word_last_q)
   );

endmodule

`default_nettype wire

// [design/dmb_pkg.sv]
// Constants shared by the mode register and burst configuration block.
// Assumes a single 20 MHz clock domain; every count below is in its cycles.
package dmb_pkg;

   // -----------------------------------------------------------------
   // Command codes presented by the controller front end
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_NOP = 3'h0,
      CMD_MODE_REG_WRITE = 3'h1,
      CMD_MODE_REG_READ = 3'h2,
      CMD_ZQ_CAL_BEGIN = 3'h3,
      CMD_ZQ_CAL_APPLY = 3'h4,
      CMD_READ = 3'h5,
      CMD_WRITE = 3'h6
   } dmb_cmd_e;

   // -----------------------------------------------------------------
   // Mode register addresses
   // -----------------------------------------------------------------
   localparam logic [5:0] MA_STATUS = 6'h00;
   localparam logic [5:0] MA_BURST_PREAMBLE = 6'h01;
   localparam logic [5:0] MA_SETPOINT = 6'h0d;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int STS_TERM_BIT = 7;
   localparam int STS_ZQ_LSB = 3;
   localparam int CFG_BL_LSB = 0;
   localparam int CFG_WR_PRE_BIT = 2;
   localparam int CFG_RD_PRE_BIT = 3;
   localparam int CFG_NWR_LSB = 4;
   localparam int CFG_READ_POSTAMBLE_LEN_BIT = 7;
   localparam int SP_WRITE_BIT = 6;
   localparam int SP_OPERATE_BIT = 7;

   // -----------------------------------------------------------------
   // Reset values and encodings
   // -----------------------------------------------------------------
   localparam logic [7:0] CFG_RESET = 8'h04;
   localparam logic [1:0] BL_FIXED16 = 2'h0;
   localparam logic [1:0] BL_FIXED32 = 2'h1;
   localparam logic [1:0] BL_ON_THE_FLY = 2'h2;
   localparam logic [1:0] ZQ_NONE = 2'h0;
   localparam logic [1:0] ZQ_DEFAULT_CAL = 2'h1;
   localparam logic [1:0] ZQ_OPEN_OR_SHORT = 2'h2;
   localparam logic [1:0] ZQ_RES_FOUND = 2'h3;

   // -----------------------------------------------------------------
   // Write recovery counts, indexed by the three-bit code
   // -----------------------------------------------------------------
   localparam logic [5:0] NWR_C0 = 6'h06;
   localparam logic [5:0] NWR_C1 = 6'h0a;
   localparam logic [5:0] NWR_C2 = 6'h10;
   localparam logic [5:0] NWR_C3 = 6'h14;
   localparam logic [5:0] NWR_C4 = 6'h18;
   localparam logic [5:0] NWR_C5 = 6'h1e;
   localparam logic [5:0] NWR_C6 = 6'h22;
   localparam logic [5:0] NWR_C7 = 6'h28;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int ZQ_APPLY_WAIT_NS = 30;
   localparam int ZQ_APPLY_RAW = (ZQ_APPLY_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ZQ_APPLY_CYC = (ZQ_APPLY_RAW < 1) ? 1 : ZQ_APPLY_RAW;
   localparam int BURST16_LAST = 15;
   localparam int BURST32_LAST = 31;

endpackage

// [design/dmb_read_burst_seq.sv]
// Read burst word order generator: one word address per clock.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module dmb_read_burst_seq (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic len32,
   input wire logic [2:0] col,
   output logic word_valid_q,
   output logic [4:0] word_addr_q,
   output logic word_last_q
);

   // -----------------------------------------------------------------
   // Order function
   // -----------------------------------------------------------------
   // Rotates inside a 16-word half; a 32-word burst then continues in the other half
   function automatic logic [4:0] seq_addr(input logic [2:0] c, input logic l32, input logic [4:0] k);
      logic [3:0] lo;
      lo = {c[1:0], 2'h0} + k[3:0];
      seq_addr = {l32 & (c[2] ^ k[4]), lo};
   endfunction

   logic [4:0] k_q;
   logic [2:0] col_q;
   logic len_q;

   // -----------------------------------------------------------------
   // Sequencer
   // -----------------------------------------------------------------
   // A start during a running burst is dropped; the caller does not hold it back
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         word_valid_q <= 1'b0;
         word_addr_q <= 5'h00;
         word_last_q <= 1'b0;
         k_q <= 5'h00;
         col_q <= 3'h0;
         len_q <= 1'b0;
      end else if (start && !word_valid_q) begin
         word_valid_q <= 1'b1;
         word_addr_q <= seq_addr(col, len32, 5'h00);
         word_last_q <= 1'b0;
         k_q <= 5'h01;
         col_q <= col;
         len_q <= len32;
      end else if (word_valid_q) begin
         if (word_last_q) begin
            word_valid_q <= 1'b0;
            word_last_q <= 1'b0;
         end else begin
            word_addr_q <= seq_addr(col_q, len_q, k_q);
            word_last_q <= (k_q == (len_q ? 5'(dmb_pkg::BURST32_LAST) : 5'(dmb_pkg::BURST16_LAST)));
            k_q <= k_q + 5'h01;
         end
      end
   end

endmodule

`default_nettype wire

// [verification/dmb_ctrl_model.sv]
// Memory controller model driving the command port.
// Assumes tasks are called just after a rising edge of ref_clk.
`timescale 1ns/1ps
`default_nettype none

module dmb_ctrl_model (
   input wire logic ref_clk,
   output logic cmd_valid,
   output logic [2:0] cmd_code,
   output logic [5:0] cmd_ma,
   output logic [7:0] cmd_op,
   output logic cmd_bl32,
   output logic cmd_ap,
   output logic [2:0] cmd_col,
   output logic wr_burst_end
);
   // Idle command port at time zero
   initial begin
      cmd_valid = 1'h0;
      cmd_code = 3'h0;
      cmd_ma = 6'h00;
      cmd_op = 8'h00;
      cmd_bl32 = 1'h0;
      cmd_ap = 1'h0;
      cmd_col = 3'h0;
      wr_burst_end = 1'h0;
   end

   // One command, then an idle cycle; idle lines are scrambled on purpose
   task automatic send(input logic [2:0] code, input logic [5:0] ma, input logic [7:0] op,
                       input logic bl32, input logic [2:0] col);
      @(posedge ref_clk);
      cmd_valid <= 1'h1;
      cmd_code <= code;
      cmd_ma <= ma;
      cmd_op <= (code == 3'h1 && ma == 6'h01) ? (op | 8'h04) : op;
      cmd_bl32 <= bl32;
      cmd_ap <= (code == 3'h6);
      cmd_col <= col;
      @(posedge ref_clk);
      cmd_valid <= 1'h0;
      cmd_ma <= ~ma;
      cmd_op <= ~op;
      cmd_col <= ~col;
   endtask

   // End of a write burst as a one-cycle pulse
   task automatic burst_end;
      @(posedge ref_clk);
      wr_burst_end <= 1'h1;
      @(posedge ref_clk);
      wr_burst_end <= 1'h0;
   endtask
endmodule

`default_nettype wire

// [verification/dmb_mode_config_assertions.sv]
// Port checker for the mode register bank.
// Assumes one clock, ref_clk, and a synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none

module dmb_mode_config_chk (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [2:0] cmd_code,
   input wire logic [5:0] cmd_ma,
   input wire logic mrr_valid_q,
   input wire logic [7:0] mrr_data_q,
   input wire logic wr_preamble_2tck_q,
   input wire logic [5:0] write_recovery_cycles_q,
   input wire logic driver_factory_trim_q,
   input wire logic zq_code_update_q,
   input wire logic zq_result_valid_q,
   input wire logic rd_word_valid_q,
   input wire logic [4:0] rd_word_addr_q,
   input wire logic rd_word_last_q
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   logic mrr_cmd;
   logic [5:0] beat_q;
   assign mrr_cmd = cmd_valid && cmd_code == dmb_pkg::CMD_MODE_REG_READ;

   // Word index inside the running read burst, zero on its first word
   always_ff @(posedge ref_clk) begin
      if (rst || !rd_word_valid_q || rd_word_last_q) begin
         beat_q <= 6'h00;
      end else begin
         beat_q <= beat_q + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   mrr_answer_a: assert property (mrr_cmd |=> mrr_valid_q)
      else $error("mode read not answered next cycle");
   mrr_spurious_a: assert property (!mrr_cmd |=> !mrr_valid_q)
      else $error("mode read answer without a request");
   status_hidden_a: assert property ((mrr_cmd && cmd_ma == 6'h00 && !zq_result_valid_q) ##1 !zq_result_valid_q
      |-> mrr_data_q[4:3] == 2'h0 && mrr_data_q[2:0] == 3'h0)
      else $error("self-test field shown before calibration");
   zq_after_apply_a: assert property ($rose(zq_result_valid_q) |-> $past(cmd_valid && cmd_code == 3'h4, 2))
      else $error("result valid without an apply command");
   reset_clear_a: assert property ($fell(rst) |-> !zq_result_valid_q && !driver_factory_trim_q
      && write_recovery_cycles_q == 6'h06 && wr_preamble_2tck_q)
      else $error("state not cleared by reset");
   trim_valid_a: assert property (driver_factory_trim_q |-> zq_result_valid_q)
      else $error("factory trim without a completed self-test");
   update_good_a: assert property (zq_code_update_q |-> zq_result_valid_q && !driver_factory_trim_q)
      else $error("calibration update after assembly error");
   nwr_legal_a: assert property (write_recovery_cycles_q inside
      {6'h06, 6'h0a, 6'h10, 6'h14, 6'h18, 6'h1e, 6'h22, 6'h28})
      else $error("write recovery count outside the table");
   nwr_cause_a: assert property ($changed(write_recovery_cycles_q) && !$past(rst)
      |-> $past(cmd_valid && cmd_code == 3'h1, 2))
      else $error("write recovery changed without a mode write");
   burst_last_a: assert property (rd_word_last_q |-> rd_word_valid_q && (beat_q == 6'h0f || beat_q == 6'h1f))
      else $error("read burst not 16 or 32 words");
   addr_step_a: assert property (rd_word_valid_q && !rd_word_last_q
      |=> rd_word_valid_q && rd_word_addr_q[3:0] == $past(rd_word_addr_q[3:0]) + 4'h1)
      else $error("read word order not sequential");
   half_hold_a: assert property (rd_word_valid_q && !rd_word_last_q && beat_q != 6'h0f
      |=> $stable(rd_word_addr_q[4]))
      else $error("read burst left its half early");

   cover_mrr_c: cover property (mrr_cmd ##1 mrr_valid_q);
   cover_bl32_c: cover property (rd_word_last_q && beat_q == 6'h1f);
   cover_trim_c: cover property ($rose(driver_factory_trim_q));
endmodule

bind dmb_mode_config dmb_mode_config_chk u_chk (.*);

`default_nettype wire

// [verification/dmb_mode_config_tb.sv]
// Self-checking bench for the mode register bank.
// Assumes the controller model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none

module dmb_mode_config_tb;
   logic ref_clk, rst, zq_tied_vssq, ca_term_pad, cmd_valid, cmd_bl32, cmd_ap, wr_burst_end;
   logic [1:0] zq_detect, zcode;
   logic [2:0] cmd_code, cmd_col, col;
   logic [5:0] cmd_ma, write_recovery_cycles_q;
   logic [7:0] cmd_op, mrr_data_q, op, cfg0, cfg1;
   logic [4:0] rd_word_addr_q;
   logic mrr_valid_q, wr_preamble_2tck_q, rd_preamble_toggle_q, rd_postamble_long_q, precharge_start_q;
   logic driver_factory_trim_q, zq_code_update_q, zq_result_valid_q, rd_word_valid_q, rd_word_last_q;
   logic err, len32, bl32;
   logic [5:0] nwr_tab [8] = '{6'h06, 6'h0a, 6'h10, 6'h14, 6'h18, 6'h1e, 6'h22, 6'h28};
   logic [2:0] zq_cases [4] = '{3'h6, 3'h3, 3'h1, 3'h2};
   integer seed = 32'hebc443d6;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   int upd_cnt = 0;
   int i, k, n;

   dmb_ctrl_model ctl (.*);
   dmb_mode_config DUT (.*);

   // ----------------------------------------------------------------
   // Clock, timeout and update counting
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end

   // Hang guard, far past the several hundred cycles needed
   always @(posedge ref_clk) begin
      cycles++;
      if (zq_code_update_q === 1'h1) upd_cnt++;
      if (cycles >= 20000) begin
         miscompares++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // Expectations and helpers
   // ----------------------------------------------------------------
   function automatic logic [4:0] rd_addr(input logic [2:0] c, input logic l32, input logic [4:0] kk);
      logic [3:0] lo;
      lo = {c[1:0], 2'h0} + kk[3:0];
      return {l32 & (c[2] ^ kk[4]), lo};
   endfunction

   // Untied pin with code 01 or 10 is taken as an assembly fault
   function automatic logic asm_error(input logic tied, input logic [1:0] code);
      return !tied && (code == 2'h1 || code == 2'h2);
   endfunction

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic mode_reg_read_cmd(input logic [5:0] ma, input logic [7:0] exp);
      ctl.send(3'h2, ma, 8'h00, 1'h0, 3'h0);
      @(negedge ref_clk);
      chk(mrr_valid_q, 1'h1, "read strobe");
      chk(mrr_data_q, exp, "read data");
   endtask

   task automatic zq_cal;
      ctl.send(3'h3, 6'h00, 8'h00, 1'h0, 3'h0);
      ctl.send(3'h4, 6'h00, 8'h00, 1'h0, 3'h0);
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic test_done;
      $display("Checks made %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst = 1'h1;
      zq_tied_vssq = 1'h0;
      zq_detect = 2'h3;
      ca_term_pad = 1'h0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'h0;
      @(negedge ref_clk);
      chk({wr_preamble_2tck_q, rd_preamble_toggle_q, rd_postamble_long_q}, 8'h04, "reset preambles");
      chk(write_recovery_cycles_q, 6'h06, "reset recovery");
      mode_reg_read_cmd(6'h01, 8'h04);
      mode_reg_read_cmd(6'h00, 8'h00);
      ctl.send(3'h1, 6'h00, 8'hff, 1'h0, 3'h0);
      mode_reg_read_cmd(6'h05, 8'h00);
      ca_term_pad <= 1'h1;
      $display("reset test done");
      // Each pin case from reset: invalid first, then result, trim, retry
      for (i = 0; i < 4; i++) begin
         rst <= 1'h1;
         zq_tied_vssq <= zq_cases[i][2];
         zq_detect <= zq_cases[i][1:0];
         repeat (3) @(posedge ref_clk);
         rst <= 1'h0;
         repeat (2) @(posedge ref_clk);
         zcode = zq_cases[i][2] ? 2'h1 : zq_cases[i][1:0];
         err = asm_error(zq_cases[i][2], zq_cases[i][1:0]);
         mode_reg_read_cmd(6'h00, 8'h80);
         n = upd_cnt;
         zq_cal();
         chk(zq_result_valid_q, 1'h1, "result valid");
         chk(driver_factory_trim_q, err, "factory trim");
         mode_reg_read_cmd(6'h00, {1'h1, 2'h0, zcode, 3'h0});
         zq_cal();
         chk(8'(upd_cnt - n), err ? 8'h00 : 8'h02, "updates");
      end
      $display("zq test done");
      // Every recovery code, random other bits, with auto-precharge timing
      for (i = 0; i < 8; i++) begin
         op = 8'($random(seed));
         op[6:4] = i[2:0];
         cfg0 = op | 8'h04;
         ctl.send(3'h1, 6'h01, op, 1'h0, 3'h0);
         repeat (2) @(negedge ref_clk);
         chk(write_recovery_cycles_q, nwr_tab[i], "recovery count");
         chk({wr_preamble_2tck_q, rd_preamble_toggle_q, rd_postamble_long_q}, {5'h01, op[3], op[7]}, "pre/post");
         mode_reg_read_cmd(6'h01, cfg0);
         ctl.send(3'h6, 6'h00, 8'h00, 1'h0, 3'h0);
         ctl.burst_end();
         for (n = 1; n < 60; n++) begin
            @(posedge ref_clk);
            #1;
            if (precharge_start_q === 1'h1) break;
         end
         chk(8'(n), {2'h0, nwr_tab[i]}, "precharge delay");
      end
      $display("config test done");
      // Second copy: written while idle, then made active
      cfg1 = 8'($random(seed)) ^ 8'h70;
      ctl.send(3'h1, 6'h0d, 8'h40, 1'h0, 3'h0);
      ctl.send(3'h1, 6'h01, cfg1, 1'h0, 3'h0);
      cfg1 = cfg1 | 8'h04;
      @(negedge ref_clk);
      chk(write_recovery_cycles_q, nwr_tab[cfg0[6:4]], "inactive copy");
      mode_reg_read_cmd(6'h01, cfg1);
      ctl.send(3'h1, 6'h0d, 8'hc0, 1'h0, 3'h0);
      repeat (2) @(negedge ref_clk);
      chk(write_recovery_cycles_q, nwr_tab[cfg1[6:4]], "active copy");
      ctl.send(3'h1, 6'h0d, 8'h80, 1'h0, 3'h0);
      mode_reg_read_cmd(6'h01, cfg0);
      chk(rd_preamble_toggle_q, cfg1[3], "active preamble");
      ctl.send(3'h1, 6'h0d, 8'h00, 1'h0, 3'h0);
      $display("set point test done");
      // Every burst field code, two random reads each
      for (i = 0; i < 8; i++) begin
         ctl.send(3'h1, 6'h01, {6'h01, i[2:1]}, 1'h0, 3'h0);
         col = (i == 0) ? 3'h5 : 3'($random(seed));
         bl32 = 1'($random(seed));
         len32 = (i[2:1] == 2'h1) || (i[2:1] == 2'h2 && bl32);
         ctl.send(3'h5, 6'h00, 8'h00, bl32, col);
         @(negedge ref_clk);
         for (k = 0; k < (len32 ? 32 : 16); k++) begin
            chk({rd_word_valid_q, rd_word_last_q, 1'h0, rd_word_addr_q},
                {2'h2 | 2'(k == (len32 ? 31 : 15)), 1'h0, rd_addr(col, len32, 5'(k))}, "read word");
            @(negedge ref_clk);
         end
         chk(rd_word_valid_q, 1'h0, "burst over");
      end
      $display("read test done");
      test_done();
   end
endmodule

`default_nettype wire
